// >>> src/rx_port_regs_pkg.sv
/*
 * Shared constants and carrier types for the per-port receive register group.
 * Assumes a byte-wide register access port driven by the device's I2C target logic.
 */
package rx_port_regs_pkg;

    // ***********************************
    // Register offsets
    // ***********************************
    localparam logic [7:0] PORT_SELECT_ADDR   = 8'h4c;
    localparam logic [7:0] PARITY_HIGH_ADDR   = 8'h55;
    localparam logic [7:0] PARITY_LOW_ADDR    = 8'h56;
    localparam logic [7:0] SELFTEST_ADDR      = 8'h57;
    localparam logic [7:0] BACK_CFG_ADDR      = 8'h58;
    localparam logic [7:0] DATAPATH_ONE_ADDR  = 8'h59;
    localparam logic [7:0] DATAPATH_TWO_ADDR  = 8'h5a;

    // ***********************************
    // Field positions
    // ***********************************
    localparam int FORWARD_ALL_BIT    = 7;
    localparam int FORWARD_MATCH_BIT  = 6;
    localparam int ACK_ALL_BIT        = 5;
    localparam int ALWAYS_ON_BIT      = 4;
    localparam int CRC_ON_BIT         = 3;
    localparam int RATE_LSB           = 0;
    localparam int OVERRIDE_BIT       = 7;
    localparam int GPIO_LSB           = 0;

    // ***********************************
    // Reset values
    // ***********************************
    localparam logic [7:0] BACK_CFG_RESET  = 8'h18;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
    localparam logic [1:0] SELECT_RESET    = 2'h0;

    // Back channel rate codes
    typedef enum logic [2:0] {
        RATE_2M5 = 3'b000,
        RATE_10M = 3'b010,
        RATE_25M = 3'b101,
        RATE_50M = 3'b110
    } rate_t;

    // Forward channel GPIO counts
    localparam logic [2:0] GPIO_NONE = 3'h0;
    localparam logic [2:0] GPIO_ONE  = 3'h1;
    localparam logic [2:0] GPIO_TWO  = 3'h2;
    localparam logic [2:0] GPIO_FOUR = 3'h4;

    // Register access request
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic       fromRemote;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Per-port decoded controls
    typedef struct packed {
        logic       forwardAll;
        logic       forwardMatch;
        logic       ackAll;
        logic       backEnable;
        logic       crcOn;
        logic [2:0] rateCode;
        logic       rateValid;
        logic [2:0] gpioCount;
    } port_ctrl_t;

endpackage

// >>> src/rx_port_bank.sv
/*
 * One receive port's copy of the per-port registers.
 * Assumes the caller gates access strobes with its port selection.
 */
`timescale 1ns/1ps

module rx_port_bank
    import rx_port_regs_pkg::*;
#(
    parameter int COUNT_W = 16
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       pdbRise,
    input  wire logic [2:0] rateStrap,
    input  wire reg_req_t   req,
    input  wire logic       lockRise,
    input  wire logic       parityErr,
    input  wire logic [7:0] selftestCount,
    input  wire logic       fcLoad,
    input  wire logic [1:0] fcGpio,
    output logic [7:0]      rdata,
    output port_ctrl_t      ctrl
);

    // Refuse counter widths the byte read mux cannot serve
    if (COUNT_W != 16) begin : g_bad_count
        $error("COUNT_W must be 16");
    end

    typedef struct packed {
        logic [15:0] parity;
        logic [7:0]  backCfg;
        logic [7:0]  dpOne;
        logic [7:0]  dpTwo;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;
    logic        lowRead;
    logic        wrCfg;

    assign lowRead = req.rdEn && req.addr == PARITY_LOW_ADDR;
    assign wrCfg   = req.wrEn && req.addr == BACK_CFG_ADDR;

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        s_d = s_q;
        // Restart on lock or low-byte read; a new error still counts
        if (lowRead || lockRise) begin
            s_d.parity = {15'h0000, parityErr};
        end else if (parityErr && s_q.parity != 16'hffff) begin
            s_d.parity = s_q.parity + 16'h0001;
        end
        if (wrCfg) begin
            s_d.backCfg = req.wdata;
            if (req.fromRemote) begin
                s_d.backCfg[ALWAYS_ON_BIT] = s_q.backCfg[ALWAYS_ON_BIT];
            end
        end
        if (pdbRise) begin
            s_d.backCfg[RATE_LSB +: 3] = rateStrap;
        end
        if (req.wrEn && req.addr == DATAPATH_ONE_ADDR) begin
            s_d.dpOne[OVERRIDE_BIT] = req.wdata[OVERRIDE_BIT];
            s_d.dpOne[6:2] = req.wdata[6:2];
            if (s_q.dpOne[OVERRIDE_BIT]) begin
                s_d.dpOne[GPIO_LSB +: 2] = req.wdata[GPIO_LSB +: 2];
            end
        end else if (fcLoad && !s_q.dpOne[OVERRIDE_BIT]) begin
            s_d.dpOne[GPIO_LSB +: 2] = fcGpio;
        end
        if (req.wrEn && req.addr == DATAPATH_TWO_ADDR) begin
            s_d.dpTwo = req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '{parity: 16'h0000, backCfg: BACK_CFG_RESET,
                     dpOne: ZERO_BYTE, dpTwo: ZERO_BYTE};
        end else begin
            s_q <= s_d;
        end
    end

    // ***********************************
    // Read mux and decoded controls
    // ***********************************
    always_comb begin
        unique case (req.addr)
            PARITY_HIGH_ADDR:  rdata = s_q.parity[15:8];
            PARITY_LOW_ADDR:   rdata = s_q.parity[7:0];
            SELFTEST_ADDR:     rdata = selftestCount;
            BACK_CFG_ADDR:     rdata = s_q.backCfg;
            DATAPATH_ONE_ADDR: rdata = s_q.dpOne;
            DATAPATH_TWO_ADDR: rdata = s_q.dpTwo;
            default:           rdata = ZERO_BYTE;
        endcase
    end

    always_comb begin
        ctrl.forwardAll   = s_q.backCfg[FORWARD_ALL_BIT];
        ctrl.forwardMatch = s_q.backCfg[FORWARD_MATCH_BIT];
        ctrl.ackAll       = s_q.backCfg[ACK_ALL_BIT];
        ctrl.backEnable   = s_q.backCfg[ALWAYS_ON_BIT]
                          | s_q.backCfg[FORWARD_ALL_BIT] | s_q.backCfg[FORWARD_MATCH_BIT];
        ctrl.crcOn        = s_q.backCfg[CRC_ON_BIT];
        ctrl.rateCode     = s_q.backCfg[RATE_LSB +: 3];
        unique case (s_q.backCfg[RATE_LSB +: 3])
            RATE_2M5, RATE_10M, RATE_25M, RATE_50M: ctrl.rateValid = 1'b1;
            default:                                ctrl.rateValid = 1'b0;
        endcase
        unique case (s_q.dpOne[GPIO_LSB +: 2])
            2'b00:   ctrl.gpioCount = GPIO_NONE;
            2'b01:   ctrl.gpioCount = GPIO_ONE;
            2'b10:   ctrl.gpioCount = GPIO_TWO;
            2'b11:   ctrl.gpioCount = GPIO_FOUR;
        endcase
    end

endmodule

// >>> src/rx_port_back_channel_config_regs.sv
/*
 * Two-port register group: port select, parity counters, self-test count,
 * back channel and datapath configuration, with forward channel loading.
 * Assumes a one-cycle register strobe interface from the I2C target logic.
 */
// Function
// - Port-select register routes accesses per port
// - Count parity errors; restart on lock, read
// - Low byte read returns, then clears
// - High byte holds upper bits, cleared too
// - Self-test error count is read-only byte
// - Forward-all bit forwards every transaction
// - Forward-on-match forwards matching transactions only
// - Acknowledge-all bit acknowledges every write
// - Always-on, else enabled by forwarding bits
// - Always-on writable only by local controller
// - CRC generator follows its enable bit
// - Rate codes 000,010,101,110; others reserved
// - Rate reset value loaded from strap
// - Override bit blocks forward channel loading
// - GPIO count codes none, one, two, four
// - GPIO count written locally only with override
`timescale 1ns/1ps

module rx_port_back_channel_config_regs
    import rx_port_regs_pkg::*;
#(
    parameter int PORTS = 2
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    powerDownPin,
    input  wire logic [2:0]              rateStrap,
    input  wire reg_req_t                req,
    input  wire logic [PORTS-1:0]        lockRise,
    input  wire logic [PORTS-1:0]        parityErr,
    input  wire logic [PORTS*8-1:0]      selftestCount,
    input  wire logic [PORTS-1:0]        fcLoad,
    input  wire logic [PORTS*2-1:0]      fcGpio,
    output logic [7:0]                   rdata,
    output port_ctrl_t [PORTS-1:0]       portCtrl
);

    // Refuse port counts the read mux cannot serve
    if (PORTS != 2) begin : g_bad_ports
        $error("PORTS must be 2");
    end

    typedef struct packed {
        logic [1:0]                  sel;
        logic                        pdbPrev;
        logic [7:0]                  rdata;
        port_ctrl_t [PORTS-1:0]      ctrl;
    } top_state_t;

    top_state_t           s_q;
    top_state_t           s_d;
    logic                 pdbRise;
    logic [PORTS*8-1:0]   bankData;
    port_ctrl_t [PORTS-1:0] bankCtrl;

    assign pdbRise = powerDownPin && !s_q.pdbPrev;

    // ***********************************
    // Per-port banks
    // ***********************************
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        reg_req_t portReq;
        always_comb begin
            portReq      = req;
            portReq.wrEn = req.wrEn && s_q.sel[p];
            portReq.rdEn = req.rdEn && s_q.sel[p];
        end
        rx_port_bank #(.COUNT_W(16)) u_bank (
            .clk           (clk),
            .srst          (srst),
            .pdbRise       (pdbRise),
            .rateStrap     (rateStrap),
            .req           (portReq),
            .lockRise      (lockRise[p]),
            .parityErr     (parityErr[p]),
            .selftestCount (selftestCount[p*8 +: 8]),
            .fcLoad        (fcLoad[p]),
            .fcGpio        (fcGpio[p*2 +: 2]),
            .rdata         (bankData[p*8 +: 8]),
            .ctrl          (bankCtrl[p])
        );
    end

    // ***********************************
    // Select register, read data, control outputs
    // ***********************************
    always_comb begin
        s_d         = s_q;
        s_d.pdbPrev = powerDownPin;
        s_d.ctrl    = bankCtrl;
        if (req.wrEn && req.addr == PORT_SELECT_ADDR) begin
            s_d.sel = req.wdata[1:0];
        end
        if (req.rdEn) begin
            if (req.addr == PORT_SELECT_ADDR) begin
                s_d.rdata = {6'h00, s_q.sel};
            end else if (s_q.sel[0]) begin
                s_d.rdata = bankData[7:0];
            end else if (s_q.sel[1]) begin
                s_d.rdata = bankData[15:8];
            end else begin
                s_d.rdata = ZERO_BYTE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '{sel: SELECT_RESET, pdbPrev: 1'b0, rdata: ZERO_BYTE, ctrl: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata    = s_q.rdata;
    assign portCtrl = s_q.ctrl;

    // ***********************************
    // Checks
    // ***********************************
    a_lowread_clears: assert property (@(posedge clk) disable iff (srst)
        req.rdEn && req.addr == PARITY_LOW_ADDR && s_q.sel[0] && !parityErr[0]
        |=> g_port[0].u_bank.s_q.parity == 16'h0000)
        else $error("parity count not cleared by low byte read");
    a_lock_restarts: assert property (@(posedge clk) disable iff (srst)
        lockRise[0] && !parityErr[0] |=> g_port[0].u_bank.s_q.parity == 16'h0000)
        else $error("parity count not restarted on lock");
    a_remote_alwayson: assert property (@(posedge clk) disable iff (srst)
        req.wrEn && req.fromRemote && req.addr == BACK_CFG_ADDR && s_q.sel[0]
        |=> $stable(g_port[0].u_bank.s_q.backCfg[ALWAYS_ON_BIT]))
        else $error("remote write changed always-on bit");
    a_back_enable: assert property (@(posedge clk) disable iff (srst)
        !g_port[0].u_bank.s_q.backCfg[ALWAYS_ON_BIT]
        && !g_port[0].u_bank.s_q.backCfg[FORWARD_ALL_BIT]
        && !g_port[0].u_bank.s_q.backCfg[FORWARD_MATCH_BIT] |=> !portCtrl[0].backEnable)
        else $error("back channel on without always-on or forwarding");
    a_back_forced: assert property (@(posedge clk) disable iff (srst)
        g_port[0].u_bank.s_q.backCfg[ALWAYS_ON_BIT] |=> portCtrl[0].backEnable)
        else $error("back channel off while always-on set");
    a_gpio_locked: assert property (@(posedge clk) disable iff (srst)
        !g_port[0].u_bank.s_q.dpOne[OVERRIDE_BIT] && !fcLoad[0]
        |=> $stable(g_port[0].u_bank.s_q.dpOne[1:0]))
        else $error("gpio count changed without load or override");
    a_override_holds: assert property (@(posedge clk) disable iff (srst)
        g_port[0].u_bank.s_q.dpOne[OVERRIDE_BIT] && fcLoad[0] && !req.wrEn
        |=> $stable(g_port[0].u_bank.s_q.dpOne))
        else $error("forward load overwrote override value");
    a_strap_rate: assert property (@(posedge clk) disable iff (srst)
        powerDownPin && !s_q.pdbPrev |=> g_port[0].u_bank.s_q.backCfg[2:0] == $past(rateStrap))
        else $error("rate not loaded from strap");
    a_select_route: assert property (@(posedge clk) disable iff (srst)
        req.wrEn && req.addr == BACK_CFG_ADDR && s_q.sel == 2'b10
        |=> $stable(g_port[0].u_bank.s_q.backCfg))
        else $error("unselected port was written");
    a_select_other: assert property (@(posedge clk) disable iff (srst)
        req.wrEn && req.addr == BACK_CFG_ADDR && s_q.sel == 2'b01 && !pdbRise
        |=> $stable(g_port[1].u_bank.s_q.backCfg))
        else $error("unselected second port was written");

endmodule

// >>> test/serializer_model.sv
/*
 * Remote serializer stand-in: parity error pulses, lock events and
 * forward channel GPIO count loads for each receive port.
 * Assumes the bench calls its tasks; outputs change at falling edges.
 */
`timescale 1ns/1ps

module serializer_model (
    input  wire logic clk,
    output logic [1:0] parityErr,
    output logic [1:0] lockRise,
    output logic [1:0] fcLoad,
    output logic [3:0] fcGpio
);
    initial begin
        parityErr = 2'h0;
        lockRise  = 2'h0;
        fcLoad    = 2'h0;
        fcGpio    = 4'ha;
    end

    // Error line held n cycles: one counted error per cycle
    task automatic send_errors(input int p, input int n);
        @(negedge clk) parityErr[p] = 1'b1;
        repeat (n) @(negedge clk);
        parityErr[p] = 1'b0;
    endtask

    // Valid lock newly seen
    task automatic lock(input int p);
        @(negedge clk) lockRise[p] = 1'b1;
        @(negedge clk) lockRise[p] = 1'b0;
    endtask

    // Count delivered over the link, then the bus no longer holds it
    task automatic load_gpio(input int p, input logic [1:0] v);
        @(negedge clk);
        fcGpio[2*p +: 2] = v;
        fcLoad[p] = 1'b1;
        @(negedge clk) fcLoad[p] = 1'b0;
        fcGpio = ~fcGpio;
    endtask
endmodule

// >>> test/tb.sv
/*
 * Self-checking bench for the two-port receive register group.
 * Assumes the serializer model beside it and one-cycle register strobes.
 */
`timescale 1ns/1ps

module tb;
    import rx_port_regs_pkg::*;
    logic             clk = 1'b0;
    logic             srst = 1'b1;
    logic             powerDownPin = 1'b0;
    logic [2:0]       rateStrap = 3'b110;
    reg_req_t         req = '0;
    logic [15:0]      selftestCount = 16'h5a3c;
    logic [1:0]       parityErr, lockRise, fcLoad;
    logic [3:0]       fcGpio;
    logic [7:0]       rdata;
    port_ctrl_t [1:0] portCtrl;
    int               err_total = 0;
    int               compares = 0;

    always #10 clk = ~clk;

    rx_port_back_channel_config_regs #(.PORTS(2)) uut (.clk(clk), .srst(srst),
        .powerDownPin(powerDownPin), .rateStrap(rateStrap), .req(req),
        .lockRise(lockRise), .parityErr(parityErr), .selftestCount(selftestCount),
        .fcLoad(fcLoad), .fcGpio(fcGpio), .rdata(rdata), .portCtrl(portCtrl));

    serializer_model sm (.clk(clk), .parityErr(parityErr), .lockRise(lockRise),
        .fcLoad(fcLoad), .fcGpio(fcGpio));

    // ***********************************
    // Bus cycles and comparison
    // ***********************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic remote = 1'b0);
        @(negedge clk);
        req = '{wrEn: 1'b1, rdEn: 1'b0, fromRemote: remote, addr: a, wdata: d};
        @(negedge clk) req.wrEn = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge clk);
        req = '{wrEn: 1'b0, rdEn: 1'b1, fromRemote: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk) req.rdEn = 1'b0;
        chk(name, exp, rdata);
    endtask

    // Forward-all, match, ack-all, back channel on, CRC on
    function automatic logic [7:0] ctl5();
        return {3'h0, portCtrl[0].forwardAll, portCtrl[0].forwardMatch,
                portCtrl[0].ackAll, portCtrl[0].backEnable, portCtrl[0].crcOn};
    endfunction

    // ***********************************
    // Scenarios
    // ***********************************
    task automatic t_strap();
        wr(PORT_SELECT_ADDR, 8'h01);
        rd(BACK_CFG_ADDR, 8'h18, "cfg reset");
        powerDownPin = 1'b1;
        repeat (3) @(negedge clk);
        rd(BACK_CFG_ADDR, 8'h1e, "cfg strap");
        chk("ctl reset", 8'h03, ctl5());
    endtask

    task automatic t_rates();
        for (int c = 0; c < 8; c++) begin
            wr(BACK_CFG_ADDR, {5'h03, 3'(c)});
            chk("rate", {5'h0, 3'(c)}, {5'h0, portCtrl[0].rateCode});
            chk("rate ok", {7'h0, c inside {0, 2, 5, 6}}, {7'h0, portCtrl[0].rateValid});
        end
    endtask

    task automatic t_config();
        wr(BACK_CFG_ADDR, 8'h80);
        chk("fwd all", 8'h12, ctl5());
        wr(BACK_CFG_ADDR, 8'h40);
        chk("fwd match", 8'h0a, ctl5());
        wr(BACK_CFG_ADDR, 8'h20);
        chk("ack all", 8'h04, ctl5());
        wr(BACK_CFG_ADDR, 8'h1a, 1'b1);
        rd(BACK_CFG_ADDR, 8'h0a, "remote on");
        wr(BACK_CFG_ADDR, 8'h18);
        chk("local on", 8'h03, ctl5());
    endtask

    task automatic t_parity();
        sm.send_errors(0, 300);
        sm.send_errors(1, 3);
        rd(PARITY_HIGH_ADDR, 8'h01, "par hi");
        rd(PARITY_LOW_ADDR, 8'h2c, "par lo");
        rd(PARITY_LOW_ADDR, 8'h00, "par lo clr");
        rd(PARITY_HIGH_ADDR, 8'h00, "par hi clr");
        sm.send_errors(0, 7);
        sm.lock(0);
        rd(PARITY_LOW_ADDR, 8'h00, "par lock");
        wr(PORT_SELECT_ADDR, 8'h02);
        rd(PARITY_LOW_ADDR, 8'h03, "par port1");
        rd(SELFTEST_ADDR, 8'h5a, "selftest");
        rd(BACK_CFG_ADDR, 8'h1e, "cfg port1");
        wr(BACK_CFG_ADDR, 8'h80);
        rd(BACK_CFG_ADDR, 8'h80, "cfg port1 wr");
        chk("port1 fwd", 8'h01, {7'h0, portCtrl[1].forwardAll});
        chk("port0 kept", 8'h03, ctl5());
        rd(8'h5b, 8'h00, "unmapped");
        wr(PORT_SELECT_ADDR, 8'h01);
    endtask

    task automatic t_gpio();
        logic [7:0] cnt[4] = '{8'h0, 8'h1, 8'h2, 8'h4};
        sm.load_gpio(0, 2'b11);
        wr(DATAPATH_ONE_ADDR, 8'h01);
        chk("gpio load", 8'h04, {5'h0, portCtrl[0].gpioCount});
        wr(DATAPATH_ONE_ADDR, 8'h80);
        for (int i = 0; i < 4; i++) begin
            wr(DATAPATH_ONE_ADDR, 8'h80 | 8'(i));
            chk("gpio code", cnt[i], {5'h0, portCtrl[0].gpioCount});
        end
        sm.load_gpio(0, 2'b10);
        repeat (2) @(negedge clk);
        chk("gpio held", 8'h04, {5'h0, portCtrl[0].gpioCount});
        wr(DATAPATH_ONE_ADDR, 8'h00);
        sm.load_gpio(0, 2'b10);
        repeat (2) @(negedge clk);
        chk("gpio free", 8'h02, {5'h0, portCtrl[0].gpioCount});
    endtask

    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        t_strap();
        t_rates();
        t_config();
        t_parity();
        t_gpio();
        print_verdict();
    end

    // Watchdog
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule
